// ==== rtl/bms_pkg.sv ====
// shared constants and types of the boot-mode and status pin controller
// assumes a 125 MHz system clock and a 32-bit apb register bus
package bms_pkg;

	////////////////////////////////////////////////////////////////////////
	// clock and timing
	localparam int unsigned CLK_NS = 8;
	localparam int unsigned CLK_HZ = 125_000_000;
	// reset output held low this long after every reset source is gone
	localparam int unsigned RST_HOLD_NS = 1000;
	localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
	// width of an external i/o read or write strobe
	localparam int unsigned STROBE_NS = 48;
	localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	// fixed bit rate of the asynchronous cold boot
	localparam int unsigned BOOT_BAUD = 2400;
	localparam int unsigned BOOT_BAUD_DIV = CLK_HZ / BOOT_BAUD;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_BOOT = 8'h04;
	localparam logic [7:0] REG_PA_OUT = 8'h08;
	localparam logic [7:0] REG_PA_DIR = 8'h0c;
	localparam logic [7:0] REG_PB_OUT = 8'h10;
	localparam logic [7:0] REG_PB_DIR = 8'h14;
	localparam logic [7:0] REG_PG_OUT = 8'h18;
	localparam logic [7:0] REG_PG_DIR = 8'h1c;
	localparam logic [7:0] REG_PINS = 8'h20;

	// control register field positions
	localparam int unsigned CTRL_FUNC_LSB = 0;
	localparam int unsigned CTRL_LEVEL_BIT = 2;
	localparam int unsigned CTRL_XBUS_BIT = 3;
	localparam int unsigned CTRL_AUX_BIT = 4;
	localparam int unsigned CTRL_SERE_BIT = 5;
	// pin readback field positions
	localparam int unsigned PINS_PB_LSB = 8;
	localparam int unsigned PINS_PG_LSB = 16;

	////////////////////////////////////////////////////////////////////////
	// status output functions
	typedef enum logic [1:0] {
		STAT_OPFETCH = 2'h0,
		STAT_INTACK = 2'h1,
		STAT_GPO = 2'h2,
		STAT_RSVD = 2'h3
	} bms_stat_e;

	// startup procedure, encoded as {boot_select_hi, boot_select_lo}
	typedef enum logic [1:0] {
		BOOT_ADDR_ZERO = 2'h0,
		BOOT_CLK_SER_A = 2'h1,
		BOOT_SLAVE = 2'h2,
		BOOT_ASYNC_SER_A = 2'h3
	} bms_boot_e;

	// external i/o cycle, gray along idle-setup-strobe-hold
	typedef enum logic [1:0] {
		IO_IDLE = 2'h0,
		IO_SETUP = 2'h1,
		IO_STROBE = 2'h3,
		IO_HOLD = 2'h2
	} bms_io_e;

	localparam logic [5:0] CTRL_RESET = 6'h00;

	typedef struct packed {
		logic serialEEn;
		logic auxAddrEn;
		logic extBusEn;
		logic statusLevel;
		bms_stat_e statusFunc;
	} bms_ctrl_s;

	typedef struct packed {
		logic valid;
		logic write;
		logic [5:0] addr;
		logic [7:0] wdata;
	} bms_io_req_s;

	typedef struct packed {
		logic done;
		logic [7:0] rdata;
	} bms_io_rsp_s;

	typedef struct packed {
		logic valid;
		logic cold;
		bms_boot_e source;
		logic [15:0] baudDiv;
	} bms_boot_s;

endpackage

// ==== rtl/bms_pin_ctrl.sv ====
// boot-mode, status, reset and alternate pin functions of the processor module
// assumes apb master on sys_clk, core strobes on sys_clk, pins asynchronous
`timescale 1ns/10ps

module bms_pin_ctrl #(
	parameter int unsigned STROBE_CYC = bms_pkg::STROBE_CYC,
	parameter int unsigned RST_HOLD_CYC = bms_pkg::RST_HOLD_CYC
) (
	input wire logic sys_clk, // system clock
	input wire logic rst, // synchronous reset
	// apb slave
	input wire logic psel, // select
	input wire logic penable, // access phase
	input wire logic pwrite, // write
	input wire logic [7:0] paddr, // byte address
	input wire logic [31:0] pwdata, // write data
	output logic pready, // ready
	output logic pslverr, // unmapped address
	output logic [31:0] prdata, // read data
	// core side
	input wire logic opFetchFirst, // first opcode fetch cycle
	input wire logic intAckCycle, // interrupt acknowledge cycle
	input wire bms_pkg::bms_io_req_s ioReq, // external i/o request
	output logic ioReqReady, // i/o engine idle
	output bms_pkg::bms_io_rsp_s ioRsp, // i/o completion
	input wire logic [19:0] coreMemAddr, // core memory address
	input wire logic [7:0] coreMemWdata, // core memory write data
	output logic [7:0] coreMemRdata, // memory read data to core
	output logic coreReset, // processor reset
	output bms_pkg::bms_boot_s bootInfo, // sampled startup procedure
	input wire logic serialETxCore, // serial e transmit from core
	input wire logic serialEClkCore, // serial e clock from core
	output logic serialERxCore, // serial e receive to core
	output logic serialEClkInCore, // serial e clock input to core
	// onboard memory, never at the headers
	output logic [19:0] memAddr, // memory address
	output logic [7:0] memWdata, // memory write data
	input wire logic [7:0] memRdata, // memory read data
	output logic memReset_n, // memory reset
	// header pins
	input wire logic boot_select_lo, // boot mode pin 0
	input wire logic boot_select_hi, // boot mode pin 1
	input wire logic resetIn_n, // external reset input
	output logic reset_out_n, // reset output to peripherals
	output logic statusPin, // status output
	output logic ext_io_write_strobe_n, // i/o write strobe
	output logic ext_io_read_strobe_n, // i/o read strobe
	input wire logic [7:0] portAIn, // port a pin level
	output logic [7:0] portAOut, // port a drive value
	output logic [7:0] portAOe, // port a drive enable
	input wire logic [5:0] portBIn, // port b bits 7:2 level
	output logic [5:0] portBOut, // port b bits 7:2 drive
	output logic [5:0] portBOe, // port b bits 7:2 enable
	input wire logic [3:0] portGIn, // port g bits 7:4 level
	output logic [3:0] portGOut, // port g bits 7:4 drive
	output logic [3:0] portGOe // port g bits 7:4 enable
);

	////////////////////////////////////////////////////////////////////////
	// elaboration checks
	// read data is taken from the two-flop synchroniser, so the strobe must outlast it
	if (STROBE_CYC < 3 || STROBE_CYC > 255) begin : g_chk_strobe
		$error("STROBE_CYC must be 3 to 255");
	end
	if (RST_HOLD_CYC < 1 || RST_HOLD_CYC > 65535) begin : g_chk_hold
		$error("RST_HOLD_CYC must be 1 to 65535");
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers, first stage read by the second only
	logic [20:0] pinMeta_q, pinSync_q;
	wire [20:0] pinRaw = {resetIn_n, boot_select_hi, boot_select_lo, portGIn, portBIn, portAIn};
	always_ff @(posedge sys_clk) begin
		pinMeta_q <= pinRaw;
		pinSync_q <= pinMeta_q;
	end
	wire [7:0] paSync = pinSync_q[7:0];
	wire [5:0] pbSync = pinSync_q[13:8];
	wire [3:0] pgSync = pinSync_q[17:14];
	wire [1:0] bootSync = pinSync_q[19:18];
	wire extResetSync = ~pinSync_q[20];

	////////////////////////////////////////////////////////////////////////
	// reset generator
	logic [15:0] holdCnt_q, holdCnt_d;
	logic inReset_q;
	wire anyReset = rst | extResetSync;
	assign holdCnt_d = anyReset ? RST_HOLD_CYC[15:0] :
		(holdCnt_q != 16'h0000) ? holdCnt_q - 16'h0001 : 16'h0000;
	wire releaseNow = inReset_q & ~anyReset & (holdCnt_q == 16'h0001);
	// a glitch-free stretch so slow peripherals see a full reset
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			holdCnt_q <= RST_HOLD_CYC[15:0];
			inReset_q <= 1'b1;
		end else begin
			holdCnt_q <= holdCnt_d;
			inReset_q <= anyReset | (inReset_q & ~releaseNow);
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			coreReset <= 1'b1;
			memReset_n <= 1'b0;
		end else begin
			coreReset <= anyReset | (inReset_q & ~releaseNow);
			memReset_n <= ~(anyReset | (inReset_q & ~releaseNow));
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reset_out_n <= 1'b0;
		end else begin
			reset_out_n <= ~(anyReset | (inReset_q & ~releaseNow));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// startup procedure sampled at release
	wire [1:0] bootSel = bootSync;
	wire bootCold = (bootSel != bms_pkg::BOOT_ADDR_ZERO);
	wire [15:0] bootDiv = (bootSel == bms_pkg::BOOT_ASYNC_SER_A) ?
		bms_pkg::BOOT_BAUD_DIV[15:0] : 16'h0000;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bootInfo <= '0;
		end else if (anyReset) begin
			bootInfo.valid <= 1'b0;
		end else if (releaseNow) begin
			bootInfo.valid <= 1'b1;
			bootInfo.cold <= bootCold;
			bootInfo.source <= bms_pkg::bms_boot_e'(bootSel);
			bootInfo.baudDiv <= bootDiv;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// onboard memory path
	// memory bus stays internal
	always_ff @(posedge sys_clk) begin
		memAddr <= coreMemAddr;
		memWdata <= coreMemWdata;
		coreMemRdata <= memRdata;
	end

	////////////////////////////////////////////////////////////////////////
	// apb registers
	bms_pkg::bms_ctrl_s ctrl_q;
	logic [7:0] paOut_q, paDir_q;
	logic [5:0] pbOut_q, pbDir_q;
	logic [3:0] pgOut_q, pgDir_q;
	wire setupPhase = psel & ~penable;
	wire wrTake = psel & penable & pready & pwrite;
	wire hitCtrl = (paddr == bms_pkg::REG_CTRL);
	wire hitBoot = (paddr == bms_pkg::REG_BOOT);
	wire hitPaOut = (paddr == bms_pkg::REG_PA_OUT);
	wire hitPaDir = (paddr == bms_pkg::REG_PA_DIR);
	wire hitPbOut = (paddr == bms_pkg::REG_PB_OUT);
	wire hitPbDir = (paddr == bms_pkg::REG_PB_DIR);
	wire hitPgOut = (paddr == bms_pkg::REG_PG_OUT);
	wire hitPgDir = (paddr == bms_pkg::REG_PG_DIR);
	wire hitPins = (paddr == bms_pkg::REG_PINS);
	wire hitAny = hitCtrl | hitBoot | hitPaOut | hitPaDir | hitPbOut | hitPbDir |
		hitPgOut | hitPgDir | hitPins;
	logic ioBusy;
	wire [31:0] bootWord = {26'h0, ioBusy, bootInfo.valid, bootInfo.cold,
		bootInfo.source == bms_pkg::BOOT_ASYNC_SER_A, bootSel};
	wire [31:0] pinsWord = {12'h000, pgSync, 2'h0, pbSync, paSync};
	wire [31:0] rdMux =
		hitCtrl ? {26'h0, ctrl_q} :
		hitBoot ? bootWord :
		hitPaOut ? {24'h0, paOut_q} :
		hitPaDir ? {24'h0, paDir_q} :
		hitPbOut ? {26'h0, pbOut_q} :
		hitPbDir ? {26'h0, pbDir_q} :
		hitPgOut ? {28'h0, pgOut_q} :
		hitPgDir ? {28'h0, pgDir_q} :
		hitPins ? pinsWord : 32'h0000_0000;
	// answer prepared in setup, so the access phase ends on its first edge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setupPhase;
			pslverr <= setupPhase & ~hitAny;
			prdata <= (setupPhase & ~pwrite) ? rdMux : 32'h0000_0000;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (anyReset) begin
			ctrl_q <= bms_pkg::CTRL_RESET;
		end else if (wrTake & hitCtrl) begin
			ctrl_q <= pwdata[5:0];
		end
	end
	// port data and direction registers
	always_ff @(posedge sys_clk) begin
		if (anyReset) begin
			paOut_q <= 8'h00;
			paDir_q <= 8'h00;
			pbOut_q <= 6'h00;
			pbDir_q <= 6'h00;
			pgOut_q <= 4'h0;
			pgDir_q <= 4'h0;
		end else if (wrTake) begin
			if (hitPaOut) paOut_q <= pwdata[7:0];
			if (hitPaDir) paDir_q <= pwdata[7:0];
			if (hitPbOut) pbOut_q <= pwdata[5:0];
			if (hitPbDir) pbDir_q <= pwdata[5:0];
			if (hitPgOut) pgOut_q <= pwdata[3:0];
			if (hitPgDir) pgDir_q <= pwdata[3:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// external i/o cycle engine
	bms_pkg::bms_io_e ioState_q, ioState_d;
	logic [7:0] strobeCnt_q;
	logic ioWrite_q;
	logic [5:0] ioAddr_q;
	logic [7:0] ioData_q;
	assign ioBusy = (ioState_q != bms_pkg::IO_IDLE);
	wire strobeLast = (strobeCnt_q == 8'h01);
	// next state
	always_comb begin
		ioState_d = ioState_q;
		case (ioState_q)
			bms_pkg::IO_IDLE: begin
				if (ioReq.valid) ioState_d = bms_pkg::IO_SETUP;
			end
			bms_pkg::IO_SETUP: begin
				ioState_d = bms_pkg::IO_STROBE;
			end
			bms_pkg::IO_STROBE: begin
				if (strobeLast) ioState_d = bms_pkg::IO_HOLD;
			end
			bms_pkg::IO_HOLD: begin
				ioState_d = bms_pkg::IO_IDLE;
			end
			default: begin
				ioState_d = bms_pkg::IO_IDLE;
			end
		endcase
	end
	// request latched in idle, address and direction held for the whole cycle, read data loaded at the last strobe clock
	always_ff @(posedge sys_clk) begin
		if (anyReset) begin
			ioState_q <= bms_pkg::IO_IDLE;
			strobeCnt_q <= 8'h00;
			ioWrite_q <= 1'b0;
			ioAddr_q <= 6'h00;
			ioData_q <= 8'h00;
		end else begin
			ioState_q <= ioState_d;
			strobeCnt_q <= (ioState_q == bms_pkg::IO_SETUP) ? STROBE_CYC[7:0] :
				(strobeCnt_q != 8'h00) ? strobeCnt_q - 8'h01 : 8'h00;
			if (ioState_q == bms_pkg::IO_IDLE && ioReq.valid) begin
				ioWrite_q <= ioReq.write;
				ioAddr_q <= ioReq.addr;
				ioData_q <= ioReq.wdata;
			end else if (ioState_q == bms_pkg::IO_STROBE && strobeLast && !ioWrite_q) begin
				ioData_q <= paSync;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (anyReset) begin
			ext_io_write_strobe_n <= 1'b1;
			ext_io_read_strobe_n <= 1'b1;
			ioReqReady <= 1'b0;
			ioRsp <= '0;
		end else begin
			ext_io_write_strobe_n <= ~(ioState_d == bms_pkg::IO_STROBE & ioWrite_q);
			ext_io_read_strobe_n <= ~(ioState_d == bms_pkg::IO_STROBE & ~ioWrite_q);
			ioReqReady <= (ioState_d == bms_pkg::IO_IDLE);
			ioRsp.done <= (ioState_q == bms_pkg::IO_HOLD);
			ioRsp.rdata <= (ioState_q == bms_pkg::IO_HOLD) ? ioData_q : ioRsp.rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status pin
	logic statusNext;
	always_comb begin
		case (ctrl_q.statusFunc)
			bms_pkg::STAT_OPFETCH: statusNext = ~opFetchFirst;
			bms_pkg::STAT_INTACK: statusNext = ~intAckCycle;
			bms_pkg::STAT_GPO: statusNext = ctrl_q.statusLevel;
			default: statusNext = 1'b1;
		endcase
	end
	// registered, so the pin trails the core cycle by one clock
	always_ff @(posedge sys_clk) begin
		if (anyReset) begin
			statusPin <= 1'b1;
		end else begin
			statusPin <= statusNext;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin function muxes
	wire ioActive = (ioState_q != bms_pkg::IO_IDLE) & (ioState_d != bms_pkg::IO_IDLE);
	logic [7:0] paOutNext, paOeNext;
	logic [5:0] pbOutNext, pbOeNext;
	logic [3:0] pgOutNext, pgOeNext;
	genvar gi;
	// port a as i/o data bus
	for (gi = 0; gi < 8; gi++) begin : g_pa
		assign paOutNext[gi] = ctrl_q.extBusEn ? ioData_q[gi] : paOut_q[gi];
		assign paOeNext[gi] = ctrl_q.extBusEn ? (ioActive & ioWrite_q) : paDir_q[gi];
	end
	// port b as aux address bus
	for (gi = 0; gi < 6; gi++) begin : g_pb
		assign pbOutNext[gi] = ctrl_q.auxAddrEn ? ioAddr_q[gi] : pbOut_q[gi];
		assign pbOeNext[gi] = ctrl_q.auxAddrEn | pbDir_q[gi];
	end
	// port g as serial e: bit7 rx, bit6 tx, bit5 clock in, bit4 clock out
	assign pgOutNext = ctrl_q.serialEEn ? {1'b0, serialETxCore, 1'b0, serialEClkCore} : pgOut_q;
	assign pgOeNext = ctrl_q.serialEEn ? 4'h5 : pgDir_q;
	// all pins released while in reset
	always_ff @(posedge sys_clk) begin
		if (anyReset) begin
			portAOut <= 8'h00;
			portAOe <= 8'h00;
			portBOut <= 6'h00;
			portBOe <= 6'h00;
			portGOut <= 4'h0;
			portGOe <= 4'h0;
			serialERxCore <= 1'b1;
			serialEClkInCore <= 1'b0;
		end else begin
			portAOut <= paOutNext;
			portAOe <= paOeNext;
			portBOut <= pbOutNext;
			portBOe <= pbOeNext;
			portGOut <= pgOutNext;
			portGOe <= pgOeNext;
			serialERxCore <= ctrl_q.serialEEn ? pgSync[3] : 1'b1;
			serialEClkInCore <= ctrl_q.serialEEn ? pgSync[1] : 1'b0;
		end
	end

endmodule

// ==== tb/bms_pin_ctrl_assertions.sv ====
// port-level checker of the boot-mode and status pin controller
// assumes bind onto bms_pin_ctrl, one clock domain, strobe of 6 cycles
`timescale 1ns/10ps
module bms_pin_ctrl_assertions #(
	parameter int unsigned STROBE_CYC = 6,
	parameter int unsigned RST_HOLD_CYC = 125
) (
	input wire logic sys_clk, // clock
	input wire logic rst, // sync reset
	input wire logic psel, // apb select
	input wire logic penable, // apb access
	input wire logic pready, // apb ready
	input wire bms_pkg::bms_io_req_s ioReq, // i/o request
	input wire logic ioReqReady, // i/o idle
	input wire bms_pkg::bms_io_rsp_s ioRsp, // i/o completion
	input wire logic ext_io_write_strobe_n, // write strobe
	input wire logic ext_io_read_strobe_n, // read strobe
	input wire logic resetIn_n, // external reset
	input wire logic coreReset, // core reset
	input wire logic memReset_n, // memory reset
	input wire logic reset_out_n, // reset output
	input wire bms_pkg::bms_boot_s bootInfo // startup result
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////
	// zero wait states, ready only inside an access
	apb_ready_a: assert property (psel && !penable |=> pready && psel && penable)
		else $error("apb ready missing");
	// the 6-cycle figures hold for the default strobe width only
	wr_strobe_a: assert property ($fell(ext_io_write_strobe_n) |->
		!ext_io_write_strobe_n [*6] ##1 ext_io_write_strobe_n) else $error("write strobe width");
	rd_strobe_a: assert property ($fell(ext_io_read_strobe_n) |->
		!ext_io_read_strobe_n [*6] ##1 ext_io_read_strobe_n) else $error("read strobe width");
	io_done_a: assert property (ioReq.valid && ioReqReady |-> ##9 ioRsp.done)
		else $error("i/o done late");
	io_busy_a: assert property (ioReq.valid && ioReqReady |=> !ioReqReady [*8] ##1 ioReqReady)
		else $error("i/o busy span");
	rst_out_a: assert property (disable iff (1'b0) rst |=> !reset_out_n && coreReset)
		else $error("reset output not low");
	ext_rst_a: assert property (disable iff (1'b0) !resetIn_n [*3] |=>
		coreReset && !memReset_n) else $error("external reset ignored");
	rst_agree_a: assert property (
		reset_out_n == memReset_n && coreReset == !reset_out_n) else $error("reset mismatch");
	boot_rel_a: assert property ($rose(reset_out_n) |-> $rose(bootInfo.valid))
		else $error("boot result not at release");
	boot_cold_a: assert property (bootInfo.valid |->
		bootInfo.cold == (bootInfo.source != bms_pkg::BOOT_ADDR_ZERO)) else $error("cold flag");
	boot_baud_a: assert property (bootInfo.valid |-> bootInfo.baudDiv ==
		(bootInfo.source == bms_pkg::BOOT_ASYNC_SER_A ? 16'(bms_pkg::CLK_HZ / 2400) : 16'h0000))
		else $error("boot rate");
endmodule

bind bms_pin_ctrl bms_pin_ctrl_assertions #(.STROBE_CYC(STROBE_CYC), .RST_HOLD_CYC(RST_HOLD_CYC))
	chk_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
	.ioReq(ioReq), .ioReqReady(ioReqReady), .ioRsp(ioRsp),
	.ext_io_write_strobe_n(ext_io_write_strobe_n), .ext_io_read_strobe_n(ext_io_read_strobe_n),
	.resetIn_n(resetIn_n), .coreReset(coreReset), .memReset_n(memReset_n),
	.reset_out_n(reset_out_n), .bootInfo(bootInfo));

// ==== tb/bms_io_periph.sv ====
// external i/o peripheral and serial e echo device on the module headers
// assumes 64 byte locations addressed by port b bits 7:2
`timescale 1ns/10ps
module bms_io_periph (
	input wire logic sys_clk, // clock
	input wire logic [7:0] portAOut, // port a drive
	input wire logic [7:0] portAOe, // port a enable
	input wire logic [5:0] portBOut, // port b drive
	input wire logic [5:0] portBOe, // port b enable
	input wire logic [3:0] portGOut, // port g drive
	input wire logic [3:0] portGOe, // port g enable
	input wire logic ext_io_write_strobe_n, // write strobe
	input wire logic ext_io_read_strobe_n, // read strobe
	output logic [7:0] portAIn, // port a wire
	output logic [5:0] portBIn, // port b wire
	output logic [3:0] portGIn // port g wire
);
	logic [7:0] store [64];
	logic [7:0] aLast = 8'h00;
	logic [5:0] bLast = 6'h00;
	logic [3:0] gLast = 4'h0;
	logic [7:0] aDrv;
	logic [3:0] gDrv;

	////////////////////////////////////////////////////////////////////////
	// undriven lines toggle each cycle so a stale value never looks valid
	assign aDrv = !ext_io_read_strobe_n ? store[portBIn] : ~aLast;
	assign portAIn = (portAOe & portAOut) | (~portAOe & aDrv);
	assign portBIn = (portBOe & portBOut) | (~portBOe & ~bLast);
	// echo transmit to receive, clock out to clock in
	assign gDrv = {portGOut[2], ~gLast[2], portGOut[0], ~gLast[0]};
	assign portGIn = (portGOe & portGOut) | (~portGOe & gDrv);

	// line history and byte capture while the write strobe is low
	always @(posedge sys_clk) begin
		aLast <= portAIn;
		bLast <= portBIn;
		gLast <= portGIn;
		if (!ext_io_write_strobe_n)
			store[portBIn] <= portAIn;
	end
endmodule

// ==== tb/boot_mode_and_status_pins_tb_top.sv ====
// self-checking bench of the boot-mode and status pin controller
// assumes the peripheral model on the headers and a 125 MHz clock
`timescale 1ns/10ps
module boot_mode_and_status_pins_tb_top;
	logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, e, opFetchFirst = 1'b0, intAckCycle = 1'b0, ioReqReady, coreReset;
	bms_pkg::bms_io_req_s ioReq = '0;
	bms_pkg::bms_io_rsp_s ioRsp;
	bms_pkg::bms_boot_s bootInfo;
	logic [19:0] coreMemAddr = 20'h0, memAddr;
	logic [7:0] coreMemWdata = 8'h00, memRdata = 8'h00, coreMemRdata, memWdata, portAIn, portAOut;
	logic [7:0] portAOe, d;
	logic serialETxCore = 1'b0, serialEClkCore = 1'b0, serialERxCore, serialEClkInCore;
	logic memReset_n, boot_select_lo = 1'b0, boot_select_hi = 1'b0, resetIn_n = 1'b1;
	logic reset_out_n, statusPin, ext_io_write_strobe_n, ext_io_read_strobe_n, s;
	logic [5:0] portBIn, portBOut, portBOe, a;
	logic [3:0] portGIn, portGOut, portGOe;
	int err_total = 0, compares = 0, cyc = 0;

	bms_pin_ctrl #(.RST_HOLD_CYC(4)) dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .opFetchFirst(opFetchFirst),
		.intAckCycle(intAckCycle), .ioReq(ioReq), .ioReqReady(ioReqReady), .ioRsp(ioRsp),
		.coreMemAddr(coreMemAddr), .coreMemWdata(coreMemWdata), .coreMemRdata(coreMemRdata),
		.coreReset(coreReset), .bootInfo(bootInfo), .serialETxCore(serialETxCore),
		.serialEClkCore(serialEClkCore), .serialERxCore(serialERxCore),
		.serialEClkInCore(serialEClkInCore), .memAddr(memAddr), .memWdata(memWdata),
		.memRdata(memRdata), .memReset_n(memReset_n), .boot_select_lo(boot_select_lo),
		.boot_select_hi(boot_select_hi), .resetIn_n(resetIn_n), .reset_out_n(reset_out_n),
		.statusPin(statusPin), .ext_io_write_strobe_n(ext_io_write_strobe_n),
		.ext_io_read_strobe_n(ext_io_read_strobe_n), .portAIn(portAIn), .portAOut(portAOut),
		.portAOe(portAOe), .portBIn(portBIn), .portBOut(portBOut), .portBOe(portBOe),
		.portGIn(portGIn), .portGOut(portGOut), .portGOe(portGOe));

	bms_io_periph periph_u (.sys_clk(sys_clk), .portAOut(portAOut), .portAOe(portAOe),
		.portBOut(portBOut), .portBOe(portBOe), .portGOut(portGOut), .portGOe(portGOe),
		.ext_io_write_strobe_n(ext_io_write_strobe_n), .ext_io_read_strobe_n(ext_io_read_strobe_n),
		.portAIn(portAIn), .portBIn(portBIn), .portGIn(portGIn));

	////////////////////////////////////////////////////////////////////////
	// clock, and a cycle ceiling well above the planned run
	initial forever #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			final_report();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// apb transfer, entered right after a rising edge, one idle edge after release
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) begin
			@(posedge sys_clk);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wait_boot();
		int n;
		n = 0;
		while (bootInfo.valid !== 1'b1 && n < 50) begin
			@(posedge sys_clk);
			n++;
		end
		chk({reset_out_n, memReset_n, coreReset}, 3'b110);
	endtask

	// expected startup record for a boot pin pattern {hi, lo}
	function automatic logic [19:0] boot_exp(input logic [1:0] p);
		return {1'b1, p != 2'h0, p, (p == 2'h3) ? 16'(bms_pkg::CLK_HZ / 2400) : 16'h0000};
	endfunction

	task automatic boot(input logic [1:0] p);
		{boot_select_hi, boot_select_lo} <= p;
		rst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk({reset_out_n, memReset_n}, 2'b00);
		rst <= 1'b0;
		wait_boot();
		{boot_select_hi, boot_select_lo} <= ~p;
		repeat (4) @(posedge sys_clk);
		chk(32'(bootInfo), boot_exp(p));
	endtask

	// one external i/o transfer with pin checks during the strobe
	task automatic io(input logic wr, input logic [5:0] ad, input logic [7:0] wd);
		ioReq <= '{valid: 1'b1, write: wr, addr: ad, wdata: wd};
		@(posedge sys_clk);
		while (ioReqReady !== 1'b1) begin
			@(posedge sys_clk);
		end
		ioReq.valid <= 1'b0;
		while ((wr ? ext_io_write_strobe_n : ext_io_read_strobe_n) !== 1'b0) begin
			@(posedge sys_clk);
		end
		chk({portBOut, portBOe}, {ad, 6'h3f});
		chk(portAOe, wr ? 8'hff : 8'h00);
		if (wr)
			chk(portAOut, wd);
		while (ioRsp.done !== 1'b1) begin
			@(posedge sys_clk);
		end
		@(posedge sys_clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(32'h3e2e2558));
		for (int p = 0; p < 4; p++)
			boot(2'(p));
		apb(1'b0, bms_pkg::REG_CTRL, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0000_0000);
		chk({31'h0, e}, 32'h0000_0001);
		resetIn_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk({coreReset, memReset_n}, 2'b10);
		resetIn_n <= 1'b1;
		wait_boot();
		for (int i = 0; i < 24; i++) begin
			d = 8'($urandom);
			apb(1'b1, bms_pkg::REG_CTRL, {29'h0, d[2], 2'(i % 4)});
			opFetchFirst <= d[3];
			intAckCycle <= d[4];
			coreMemAddr <= 20'($urandom);
			coreMemWdata <= d;
			memRdata <= ~d;
			repeat (2) @(posedge sys_clk);
			s = (i % 4 == 0) ? ~d[3] : (i % 4 == 1) ? ~d[4] : (i % 4 == 2) ? d[2] : 1'b1;
			chk(statusPin, s);
			chk({12'h000, memAddr}, {12'h000, coreMemAddr});
			chk({memWdata, coreMemRdata}, {d, ~d});
		end
		apb(1'b1, bms_pkg::REG_CTRL, 32'h38);
		for (int i = 0; i < 8; i++) begin
			a = 6'($urandom);
			d = 8'($urandom);
			serialETxCore <= d[0];
			serialEClkCore <= d[1];
			io(1'b1, a, d);
			io(1'b0, a, 8'h00);
			chk(ioRsp.rdata, d);
			chk({portGOe, portGOut[2], portGOut[0]}, {4'h5, d[0], d[1]});
			chk({serialERxCore, serialEClkInCore}, {d[0], d[1]});
		end
		final_report();
	end
endmodule
